// [src/pack_protect_pkg.sv]
// package: constants, modes and carriers for the pack protection pin control block
package pack_protect_pkg;

   // apb register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PIN_CFG = 8'h04;
   localparam logic [7:0] ADDR_ALARM_MASK = 8'h08;
   localparam logic [7:0] ADDR_FAULT_IN = 8'h0C;
   localparam logic [7:0] ADDR_FUSE_CFG = 8'h10;
   localparam logic [7:0] ADDR_OPEN_WIRE = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_ALARM_SRC = 8'h1C;

   // control register fields
   localparam int CTRL_HOST_CHG_OFF = 0;
   localparam int CTRL_HOST_PRECHARGE_FET_OFF = 1;
   localparam int CTRL_HOST_DSG_OFF = 2;
   localparam int CTRL_HOST_PREDISCHARGE_FET_OFF = 3;
   localparam int CTRL_DEEP = 4;
   localparam int CTRL_SLEEP = 5;
   localparam int CTRL_OSC_KEEP = 6;
   localparam int CTRL_BOTH_OFF = 7;
   localparam int CTRL_CFET_PIN_EN = 8;
   localparam int CTRL_DFET_PIN_EN = 9;
   localparam int CTRL_FUSE_SENSE_PF = 10;
   localparam int CTRL_FUSE_BLOW_EN = 11;
   localparam int CTRL_FUSE_USE_PACK = 12;
   localparam int CTRL_PF_SET = 13;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // pin configuration: 4 bits for each of 6 multifunction outputs
   localparam int PIN_CFG_W = 4;
   localparam int NUM_MF_PINS = 6;
   localparam int MF_ALARM = 0;
   localparam int MF_CFET = 1;
   localparam int MF_DFET = 2;
   localparam int MF_SWIRE = 3;
   localparam int MF_CHG_FAULT = 4;
   localparam int MF_DSG_FAULT = 5;
   localparam logic [23:0] PIN_CFG_RESET = 24'h00_0000;

   // pin function codes (low two bits) and supply/pull bits
   typedef enum logic [1:0] {FN_IDLE, FN_GPO, FN_FAULT, FN_ALARM} pin_fn_t;
   localparam int PCFG_SUPPLY = 2; // 0 internal 1v8, 1 external regulator one
   localparam int PCFG_AUX = 3;    // gpo level, or pull-up when idle

   // alarm drive styles
   typedef enum logic [1:0] {AL_LOW_HIZ, AL_HIGH_LOW, AL_LOW_HIGH, AL_SWIRE} alarm_style_t;

   // timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint SHUT_HOLD_MS = 1000;
   localparam int SHUT_HOLD_CYC = int'((SHUT_HOLD_MS * CLK_HZ) / 1000);
   localparam longint OW_TIME_US = 3000;
   localparam int OW_TIME_CYC = int'((OW_TIME_US * CLK_HZ) / 1_000_000);
   localparam int OW_INT_CYC = 100_000;
   localparam int NUM_CELLS = 14;
   localparam logic [15:0] ALARM_MASK_RESET = 16'h0000;

   // oscillator speed codes
   localparam logic [1:0] OSC_OFF = 2'h0;
   localparam logic [1:0] OSC_FAST = 2'h1; // about 262.144 khz
   localparam logic [1:0] OSC_SLOW = 2'h2; // about 32.768 khz

   // fet enables carrier
   typedef struct packed {
      logic charge_fet;
      logic precharge_fet;
      logic discharge_fet;
      logic predischarge_fet;
   } fet_en_t;

   // power control carrier
   typedef struct packed {
      logic shutdown;
      logic ext_reg_one_en;
      logic ext_reg_two_en;
      logic prereg_en;
      logic int_reg_en;
      logic [1:0] osc_mode;
   } power_ctl_t;

   // drive for one multifunction output pin
   typedef struct packed {
      logic out;
      logic oe;
      logic from_ext_reg;
      logic pull_up;
      logic pull_down;
   } pin_drive_t;

endpackage : pack_protect_pkg

// [src/pack_protect_pin_control.sv]
// design: pin level protection control of a battery monitor, with apb registers
// Function
// - discharge fault output follows discharge-disabling faults
// - charge fault output follows charge-disabling faults
// - general purpose outputs follow host level
// - high level from chosen regulator
// - weak pull up or down selectable
// - high reset pin resets most logic
// - fet and fuse state survive pin reset
// - one second high enters shutdown
// - fet-off pins turn fets off directly
// - fet returns only with no other block
// - each fet-off pin covers main and pre fet
// - both-off mode disables all four fets
// - alarm pin styles; open drain for single wire
// - three alarm drive styles
// - only masked-in sources raise alarm
// - fuse pin sensed while not driven
// - sensed fuse high may declare permanent fail
// - blow fuse only above voltage threshold
// - open wire current periodic, one measurement long
// - open wire faults cell and cell above
// - oscillator on in normal, sleep; deep configurable
// - oscillator fast in normal, slow in sleep and in deep with keep set

`timescale 1ns/1ps
`default_nettype none
module pack_protect_pin_control
   import pack_protect_pkg::*;
#(
   parameter int SHUT_CYC = SHUT_HOLD_CYC,
   parameter int OW_DEF_INT = OW_INT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic reset_shutdown_pin_i,
   input wire logic charge_fet_off_pin_i,
   input wire logic discharge_fet_off_pin_i,
   input wire logic fuse_sense_i,
   input wire logic stack_over_thr_i,
   input wire logic pack_over_thr_i,
   input wire logic [NUM_CELLS-1:0] cell_low_i,
   input wire logic [15:0] alarm_events_i,
   output fet_en_t fet_en_o,
   output logic fuse_out_o,
   output logic fuse_oe_o,
   output pin_drive_t [NUM_MF_PINS-1:0] pin_drive_o,
   output power_ctl_t power_o,
   output logic soft_reset_o,
   output logic open_wire_en_o,
   output logic [NUM_CELLS-1:0] cell_fault_o,
   output logic permanent_fail_o
);

   // three stage synchronisers for the four pins
   logic [2:0] rst_sync;
   logic [2:0] cfo_sync;
   logic [2:0] dfo_sync;
   logic [2:0] fuse_sync;

   // filtered pins
   logic rst_pin;
   logic cfo_pin;
   logic dfo_pin;
   logic fuse_pin;

   // hold timer
   logic shutdown;
   logic [31:0] shut_cnt;

   // host registers
   logic [31:0] ctrl;
   logic [23:0] pin_cfg;
   logic [15:0] alarm_mask;
   logic [3:0] fault_in;
   logic [31:0] ow_interval;
   logic [15:0] alarm_src;

   // fail state
   logic pf;
   logic fuse_drive;

   // open wire
   logic [31:0] ow_cnt;
   logic ow_on;

   // derived
   logic soft_rst_n;
   logic chg_block;
   logic dsg_block;
   logic alarm;
   fet_en_t next_fet;

   // synchronise async pins; a change counts when stages two and three agree
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync <= 3'h0;
         cfo_sync <= 3'h0;
         dfo_sync <= 3'h0;
         fuse_sync <= 3'h0;
      end else begin
         rst_sync <= {rst_sync[1:0], reset_shutdown_pin_i};
         cfo_sync <= {cfo_sync[1:0], charge_fet_off_pin_i};
         dfo_sync <= {dfo_sync[1:0], discharge_fet_off_pin_i};
         fuse_sync <= {fuse_sync[1:0], fuse_sense_i};
      end
   end

   // filtered pin levels
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_pin <= 1'b0;
         cfo_pin <= 1'b0;
         dfo_pin <= 1'b0;
         fuse_pin <= 1'b0;
      end else begin
         if (rst_sync[1] == rst_sync[2]) begin
            rst_pin <= rst_sync[2];
         end
         if (cfo_sync[1] == cfo_sync[2]) begin
            cfo_pin <= cfo_sync[2];
         end
         if (dfo_sync[1] == dfo_sync[2]) begin
            dfo_pin <= dfo_sync[2];
         end
         if (fuse_sync[1] == fuse_sync[2]) begin
            fuse_pin <= fuse_sync[2];
         end
      end
   end

   // reset pin: soft reset while high, shutdown after one second of high
   assign soft_rst_n = rstn_i & ~rst_pin;
   // hold and shutdown latch
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shut_cnt <= 32'h0000_0000;
         shutdown <= 1'b0;
      end else if (!rst_pin) begin
         shut_cnt <= 32'h0000_0000;
      end else if (shut_cnt >= 32'(SHUT_CYC - 1)) begin
         shutdown <= 1'b1;
      end else begin
         shut_cnt <= shut_cnt + 32'h0000_0001;
      end
   end

   // apb slave: zero wait states, unmapped address gives error
   assign pready_o = 1'b1;
   always_comb begin
      unique case (paddr_i)
         ADDR_CTRL, ADDR_PIN_CFG, ADDR_ALARM_MASK, ADDR_FAULT_IN, ADDR_FUSE_CFG,
         ADDR_OPEN_WIRE, ADDR_STATUS, ADDR_ALARM_SRC: pslverr_o = 1'b0;
         default: pslverr_o = psel_i & penable_i;
      endcase
   end

   // host registers; cleared by the reset pin as well
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         ctrl <= CTRL_RESET;
         pin_cfg <= PIN_CFG_RESET;
         alarm_mask <= ALARM_MASK_RESET;
         fault_in <= 4'h0;
         ow_interval <= 32'(OW_DEF_INT);
      end else if (psel_i && penable_i && pwrite_i) begin
         unique case (paddr_i)
            ADDR_CTRL: ctrl <= pwdata_i;
            ADDR_PIN_CFG: pin_cfg <= pwdata_i[23:0];
            ADDR_ALARM_MASK: alarm_mask <= pwdata_i[15:0];
            ADDR_FAULT_IN: fault_in <= pwdata_i[3:0];
            ADDR_OPEN_WIRE: ow_interval <= pwdata_i;
            default: ;
         endcase
      end
   end

   // read data register
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         unique case (paddr_i)
            ADDR_CTRL: prdata_o <= ctrl;
            ADDR_PIN_CFG: prdata_o <= {8'h00, pin_cfg};
            ADDR_ALARM_MASK: prdata_o <= {16'h0000, alarm_mask};
            ADDR_FAULT_IN: prdata_o <= {28'h000_0000, fault_in};
            ADDR_FUSE_CFG: prdata_o <= {30'h0000_0000, fuse_drive, pf};
            ADDR_OPEN_WIRE: prdata_o <= ow_interval;
            ADDR_STATUS: prdata_o <= {18'h0_0000, cell_fault_o[NUM_CELLS-1:0]} |
               {20'h0_0000, alarm, fuse_pin, dfo_pin, cfo_pin, rst_pin, 2'h0, fet_en_o, 1'b0}
               << 14;
            ADDR_ALARM_SRC: prdata_o <= {16'h0000, alarm_src};
            default: prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // fault disable sources: host register, protection faults, pins
   assign chg_block = fault_in[0] | pf | shutdown |
      (ctrl[CTRL_CFET_PIN_EN] & cfo_pin) |
      (ctrl[CTRL_BOTH_OFF] & dfo_pin);
   // both-off stops discharge too
   assign dsg_block = fault_in[1] | pf | shutdown | (|cell_fault_o) |
      ((ctrl[CTRL_DFET_PIN_EN] | ctrl[CTRL_BOTH_OFF]) & dfo_pin);
   always_comb begin
      next_fet.charge_fet = ~chg_block & ~ctrl[CTRL_HOST_CHG_OFF] & ~ctrl[CTRL_DEEP];
      next_fet.precharge_fet = ~chg_block & ~ctrl[CTRL_HOST_PRECHARGE_FET_OFF] & ~ctrl[CTRL_DEEP];
      next_fet.discharge_fet = ~dsg_block & ~ctrl[CTRL_HOST_DSG_OFF] & ~ctrl[CTRL_DEEP];
      next_fet.predischarge_fet = ~dsg_block & ~ctrl[CTRL_HOST_PREDISCHARGE_FET_OFF] & ~ctrl[CTRL_DEEP];
   end

   // fet state: cleared on the hard reset and on shutdown; otherwise held while the reset pin is high
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fet_en_o <= '0;
      end else if (shutdown) begin
         fet_en_o <= '0;
      end else if (!rst_pin) begin
         fet_en_o <= next_fet;
      end
   end

   // permanent fail and fuse: hard reset only, survives the reset pin
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pf <= 1'b0;
         fuse_drive <= 1'b0;
      end else if (!rst_pin) begin
         if ((ctrl[CTRL_FUSE_SENSE_PF] && fuse_pin && !fuse_drive) || ctrl[CTRL_PF_SET]) begin
            pf <= 1'b1;
         end
         if (pf && ctrl[CTRL_FUSE_BLOW_EN] &&
             (ctrl[CTRL_FUSE_USE_PACK] ? pack_over_thr_i : stack_over_thr_i)) begin
            fuse_drive <= 1'b1;
         end
      end
   end
   // fail and fuse pins
   assign permanent_fail_o = pf;
   assign fuse_out_o = fuse_drive;
   assign fuse_oe_o = fuse_drive;

   // open wire test: current on for one measurement time each interval
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         ow_cnt <= 32'h0000_0000;
         ow_on <= 1'b0;
      end else if (ow_cnt >= ow_interval - 32'h0000_0001) begin
         ow_cnt <= 32'h0000_0000;
         ow_on <= 1'b1;
      end else begin
         ow_cnt <= ow_cnt + 32'h0000_0001;
         if (ow_cnt >= 32'(OW_TIME_CYC - 1)) ow_on <= 1'b0;
      end
   end
   // no current in deep sleep
   assign open_wire_en_o = ow_on & ~ctrl[CTRL_DEEP] & ~shutdown;

   // cell faults: a low cell faults itself and the cell above
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         cell_fault_o <= '0;
      end else begin
         cell_fault_o <= cell_low_i | {cell_low_i[NUM_CELLS-2:0], 1'b0};
      end
   end

   // sticky alarm sources; a new event wins over a clear
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         alarm_src <= 16'h0000;
      end else if (psel_i && penable_i && pwrite_i && paddr_i == ADDR_ALARM_SRC) begin
         alarm_src <= (alarm_src & ~pwdata_i[15:0]) | alarm_events_i;
      end else begin
         alarm_src <= alarm_src | alarm_events_i;
      end
   end
   // masked alarm level
   assign alarm = |(alarm_src & alarm_mask);

   // multifunction pin drivers
   function automatic pin_drive_t drive_pin(input logic [3:0] cfg, input logic fault,
                                            input logic alm, input alarm_style_t sty);
      pin_drive_t d;

      d = '0;
      d.from_ext_reg = cfg[PCFG_SUPPLY];
      unique case (pin_fn_t'(cfg[1:0]))
         FN_IDLE: begin
            d.pull_up = cfg[PCFG_AUX];
            d.pull_down = ~cfg[PCFG_AUX];
         end

         FN_GPO: begin
            d.out = cfg[PCFG_AUX];
            d.oe = 1'b1;
         end

         FN_FAULT: begin
            d.out = fault;
            d.oe = 1'b1;
         end

         FN_ALARM: begin

            unique case (sty)
               AL_LOW_HIZ, AL_SWIRE: begin
                  d.out = 1'b0;
                  d.oe = alm;
               end

               AL_HIGH_LOW: begin
                  d.out = alm;
                  d.oe = 1'b1;
               end

               AL_LOW_HIGH: begin
                  d.out = ~alm;
                  d.oe = 1'b1;
               end
            endcase
         end
      endcase

      return d;
   endfunction

   // registered pin outputs; alarm style sits in control bits 15:14
   always_ff @(posedge clk_sys_i or negedge soft_rst_n) begin
      if (!soft_rst_n) begin
         pin_drive_o <= '0;
      end else begin
         for (int i = 0; i < NUM_MF_PINS; i++) begin
            pin_drive_o[i] <= drive_pin(pin_cfg[i*PIN_CFG_W +: PIN_CFG_W],
               (i == MF_DSG_FAULT) ? dsg_block : chg_block, alarm,
               (i == MF_SWIRE) ? AL_SWIRE : alarm_style_t'(ctrl[15:14]));
         end
      end
   end
   // reset pin level out
   assign soft_reset_o = rst_pin;

   // power and oscillator control
   always_comb begin
      power_o.shutdown = shutdown;
      power_o.ext_reg_one_en = ~shutdown & ctrl[16];
      power_o.ext_reg_two_en = ~shutdown & ctrl[17];
      power_o.prereg_en = ~shutdown & ctrl[18];
      power_o.int_reg_en = ~shutdown;
      if (shutdown) begin
         power_o.osc_mode = OSC_OFF;
      end else if (ctrl[CTRL_DEEP]) begin
         power_o.osc_mode = ctrl[CTRL_OSC_KEEP] ? OSC_SLOW : OSC_OFF;
      end else if (ctrl[CTRL_SLEEP]) begin
         power_o.osc_mode = OSC_SLOW;
      end else begin
         power_o.osc_mode = OSC_FAST;
      end
   end

endmodule : pack_protect_pin_control
`default_nettype wire

// [tb/pack_protect_pin_control_chk.sv]
// checker: port level properties of the pack protection pin control block
`timescale 1ns/1ps
`default_nettype none
module pack_protect_pin_control_chk
   import pack_protect_pkg::*;
#(
   parameter int SHUT_CYC = 50
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pslverr_o,
   input wire logic reset_shutdown_pin_i,
   input wire logic charge_fet_off_pin_i,
   input wire logic discharge_fet_off_pin_i,
   input wire logic stack_over_thr_i,
   input wire logic pack_over_thr_i,
   input wire fet_en_t fet_en_o,
   input wire logic fuse_oe_o,
   input wire power_ctl_t power_o,
   input wire logic soft_reset_o,
   input wire logic permanent_fail_o
);
   logic [31:0] ctrl;
   int hi_cnt;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // shadow of the control word, cleared while the reset pin acts
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) ctrl <= '0;
      else if (soft_reset_o) ctrl <= '0;
      else if (psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL) ctrl <= pwdata_i;
   end
   // length of the present high run on the reset pin
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) hi_cnt <= 0;
      else if (reset_shutdown_pin_i) hi_cnt <= hi_cnt + 1;
      else hi_cnt <= 0;
   end
   sequence shut_two;
      power_o.shutdown [*2];
   endsequence
   sequence cfo_held;
      (ctrl[CTRL_CFET_PIN_EN] && charge_fet_off_pin_i) [*6];
   endsequence
   sequence dfo_held;
      ((ctrl[CTRL_DFET_PIN_EN] || ctrl[CTRL_BOTH_OFF]) && discharge_fet_off_pin_i) [*6];
   endsequence
   unmapped_err_a: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0
      |-> pslverr_o == (paddr_i > ADDR_ALARM_SRC)) else $error("slave error wrong");
   shut_early_a: assert property ($rose(power_o.shutdown) |-> hi_cnt >= SHUT_CYC)
      else $error("shutdown before hold time");
   shut_off_a: assert property (shut_two |-> fet_en_o == 4'h0 && power_o == 7'h40)
      else $error("shutdown left something on");
   shut_stick_a: assert property (power_o.shutdown |=> power_o.shutdown)
      else $error("shutdown dropped");
   pin_reset_a: assert property (reset_shutdown_pin_i [*6] |-> soft_reset_o)
      else $error("reset pin not acted on");
   pin_quiet_a: assert property (!reset_shutdown_pin_i [*6] |-> !soft_reset_o)
      else $error("reset without pin");
   fet_keep_a: assert property (soft_reset_o && $past(soft_reset_o) && !power_o.shutdown
      |-> $stable(fet_en_o) && $stable(permanent_fail_o) && $stable(fuse_oe_o))
      else $error("pin reset disturbed protection state");
   cfo_off_a: assert property (cfo_held |-> !fet_en_o.charge_fet && !fet_en_o.precharge_fet)
      else $error("charge side on with pin high");
   dfo_off_a: assert property (dfo_held |-> !fet_en_o.discharge_fet && !fet_en_o.predischarge_fet
      && (!ctrl[CTRL_BOTH_OFF] || (!fet_en_o.charge_fet && !fet_en_o.precharge_fet)))
      else $error("fets on with discharge pin high");
   host_off_a: assert property (ctrl[CTRL_HOST_CHG_OFF] [*3] |-> !fet_en_o.charge_fet)
      else $error("host block ignored");
   fuse_hiz_a: assert property (!permanent_fail_o |-> !fuse_oe_o)
      else $error("fuse driven without fail");
   fuse_thr_a: assert property ($rose(fuse_oe_o)
      |-> $past(stack_over_thr_i) || $past(pack_over_thr_i)) else $error("fuse below threshold");
endmodule : pack_protect_pin_control_chk
bind pack_protect_pin_control pack_protect_pin_control_chk #(.SHUT_CYC(SHUT_CYC)) chk_i (
   .clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o,
   .reset_shutdown_pin_i, .charge_fet_off_pin_i, .discharge_fet_off_pin_i, .stack_over_thr_i,
   .pack_over_thr_i, .fet_en_o, .fuse_oe_o, .power_o, .soft_reset_o, .permanent_fail_o);
`default_nettype wire

// [tb/host_pins_model.sv]
// partner: host side control pins and the secondary fuse protector
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
   input wire logic clk_sys_i,
   input wire logic rst_cmd_i,
   input wire logic cfo_cmd_i,
   input wire logic dfo_cmd_i,
   input wire logic prot_cmd_i,
   input wire logic fuse_out_i,
   input wire logic fuse_oe_i,
   output logic reset_shutdown_pin_o,
   output logic charge_fet_off_pin_o,
   output logic discharge_fet_off_pin_o,
   output logic fuse_pin_o
);
   logic prot_q;
   // pins rest low from time zero
   initial begin
      {reset_shutdown_pin_o, charge_fet_off_pin_o, discharge_fet_off_pin_o, prot_q} = '0;
   end
   // pins move just after the edge; reset pin low unless commanded
   always @(posedge clk_sys_i) begin
      reset_shutdown_pin_o <= rst_cmd_i;
      charge_fet_off_pin_o <= cfo_cmd_i;
      discharge_fet_off_pin_o <= dfo_cmd_i;
      prot_q <= prot_cmd_i;
   end
   // device drive wins, else protector pulls high, else gate resistor pulls low
   assign fuse_pin_o = fuse_oe_i ? fuse_out_i : prot_q;
endmodule : host_pins_model
`default_nettype wire

// [tb/test_pack_protect_pin_control.sv]
// testbench: pin control block driven over apb and through its pins
`timescale 1ns/1ps
`default_nettype none
module test_pack_protect_pin_control;
   import pack_protect_pkg::*;
   logic clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic rst_cmd, cfo_cmd, dfo_cmd, prot_cmd, reset_shutdown_pin_i, charge_fet_off_pin_i;
   logic discharge_fet_off_pin_i, fuse_sense_i, stack_over_thr_i, pack_over_thr_i;
   logic fuse_out_o, fuse_oe_o, soft_reset_o, open_wire_en_o, permanent_fail_o;
   logic [NUM_CELLS-1:0] cell_low_i, cell_fault_o;
   logic [15:0] alarm_events_i;
   fet_en_t fet_en_o;
   pin_drive_t [NUM_MF_PINS-1:0] pin_drive_o;
   power_ctl_t power_o;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   pack_protect_pin_control #(.SHUT_CYC(50), .OW_DEF_INT(100)) dut (
      .clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .reset_shutdown_pin_i, .charge_fet_off_pin_i,
      .discharge_fet_off_pin_i, .fuse_sense_i, .stack_over_thr_i, .pack_over_thr_i,
      .cell_low_i, .alarm_events_i, .fet_en_o, .fuse_out_o, .fuse_oe_o, .pin_drive_o,
      .power_o, .soft_reset_o, .open_wire_en_o, .cell_fault_o, .permanent_fail_o);
   host_pins_model host (.clk_sys_i, .rst_cmd_i(rst_cmd), .cfo_cmd_i(cfo_cmd),
      .dfo_cmd_i(dfo_cmd), .prot_cmd_i(prot_cmd), .fuse_out_i(fuse_out_o),
      .fuse_oe_i(fuse_oe_o), .reset_shutdown_pin_o(reset_shutdown_pin_i),
      .charge_fet_off_pin_o(charge_fet_off_pin_i),
      .discharge_fet_off_pin_o(discharge_fet_off_pin_i), .fuse_pin_o(fuse_sense_i));
   // clock
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 80000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic check(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask : tick
   task automatic hard_reset();
      rstn_i <= 1'b0;
      tick(4);
      rstn_i <= 1'b1;
      tick(1);
   endtask : hard_reset
   // one apb transfer: setup, access until ready, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1) @(posedge clk_sys_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : apb
   task automatic t_basic();
      check(pin_drive_o === '0 && power_o === 7'h05, "reset outputs");
      apb(0, ADDR_CTRL, 32'h0);
      check(rd === CTRL_RESET && err === 1'b0, "ctrl reset value");
      apb(1, 8'h20, 32'hFFFF_FFFF);
      apb(0, 8'h20, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped access");
      apb(1, ADDR_CTRL, 32'h0000_0020);
      check(power_o.osc_mode === OSC_SLOW, "sleep osc");
      apb(1, ADDR_CTRL, 32'h0000_0050);
      check(power_o.osc_mode === OSC_SLOW, "deep osc kept");
      apb(1, ADDR_CTRL, 32'h0);
      check(power_o.osc_mode === OSC_FAST, "normal osc");
      $display("test basic done");
   endtask : t_basic
   task automatic t_fets();
      tick(3);
      check(fet_en_o === 4'hF, "fets on");
      apb(1, ADDR_CTRL, 32'h0000_0100);
      cfo_cmd <= 1'b1;
      tick(8);
      check(fet_en_o === 4'h3, "charge pin");
      apb(1, ADDR_CTRL, 32'h0000_0101);
      cfo_cmd <= 1'b0;
      tick(8);
      check(fet_en_o === 4'h7, "host block stays");
      apb(1, ADDR_CTRL, 32'h0000_0080);
      dfo_cmd <= 1'b1;
      tick(8);
      check(fet_en_o === 4'h0, "both off");
      apb(1, ADDR_CTRL, 32'h0000_0200);
      tick(4);
      check(fet_en_o === 4'hC, "discharge pin");
      dfo_cmd <= 1'b0;
      tick(8);
      check(fet_en_o === 4'hF, "fets back");
      $display("test fets done");
   endtask : t_fets
   task automatic t_pins();
      apb(1, ADDR_PIN_CFG, 32'h0022_18D0);
      apb(1, ADDR_FAULT_IN, 32'h1);
      tick(3);
      check(pin_drive_o[1] === 5'h1C && pin_drive_o[3] === 5'h08, "gpo");
      check(pin_drive_o[2].pull_up === 1'b1 && pin_drive_o[2].oe === 1'b0, "pull");
      check(pin_drive_o[4].out === 1'b1 && pin_drive_o[5].out === 1'b0, "chg f");
      apb(1, ADDR_FAULT_IN, 32'h2);
      tick(3);
      check(pin_drive_o[4].out === 1'b0 && pin_drive_o[5].out === 1'b1, "dsg f");
      $display("test pins done");
   endtask : t_pins
   task automatic t_alarm();
      apb(1, ADDR_PIN_CFG, 32'h0000_3003);
      apb(1, ADDR_ALARM_MASK, 32'h1);
      for (int s = 0; s < 3; s++) begin
         apb(1, ADDR_CTRL, 32'(s) << 14);
         alarm_events_i <= 16'h0002;
         tick(1);
         alarm_events_i <= 16'h0;
         tick(3);
         check(pin_drive_o[0].oe === (s != 0) && (s == 0 || pin_drive_o[0].out === (s == 2))
            && pin_drive_o[3].oe === 1'b0, "masked source");
         alarm_events_i <= 16'h0001;
         tick(1);
         alarm_events_i <= 16'h0;
         tick(3);
         check(pin_drive_o[0].oe === 1'b1 && pin_drive_o[0].out === (s == 1), "alarm");
         check(pin_drive_o[3] === 5'h08, "single wire open drain");
         apb(1, ADDR_ALARM_SRC, 32'h0000_FFFF);
      end
      $display("test alarm done");
   endtask : t_alarm
   task automatic t_fuse();
      apb(1, ADDR_CTRL, 32'h0000_0400);
      prot_cmd <= 1'b1;
      tick(8);
      check(permanent_fail_o === 1'b1 && fuse_oe_o === 1'b0, "sensed fail");
      prot_cmd <= 1'b0;
      apb(1, ADDR_CTRL, 32'h0000_0800);
      tick(8);
      check(fuse_oe_o === 1'b0, "below threshold");
      stack_over_thr_i <= 1'b1;
      tick(8);
      check(fuse_oe_o === 1'b1 && fuse_out_o === 1'b1, "blow");
      $display("test fuse done");
   endtask : t_fuse
   task automatic t_rst_pin();
      rst_cmd <= 1'b1;
      tick(10);
      check(soft_reset_o === 1'b1 && fuse_oe_o === 1'b1 && permanent_fail_o === 1'b1
         && power_o.shutdown === 1'b0, "pin reset");
      rst_cmd <= 1'b0;
      tick(8);
      apb(0, ADDR_CTRL, 32'h0);
      check(rd === 32'h0, "ctrl cleared");
      rst_cmd <= 1'b1;
      tick(70);
      check(power_o === 7'h40 && fet_en_o === 4'h0, "shutdown");
      rst_cmd <= 1'b0;
      stack_over_thr_i <= 1'b0;
      hard_reset();
      $display("test reset pin done");
   endtask : t_rst_pin
   task automatic t_open_wire();
      cell_low_i <= 14'h0008;
      apb(1, ADDR_OPEN_WIRE, 32'h0000_7594);
      n = 0;
      while (open_wire_en_o !== 1'b1 && n < 31000) begin
         n++;
         @(negedge clk_sys_i);
      end
      n = 0;
      while (open_wire_en_o === 1'b1 && n < 40000) begin
         n++;
         @(negedge clk_sys_i);
      end
      check(n == OW_TIME_CYC, "open wire on time");
      check(cell_fault_o === 14'h0018, "cell and cell above");
      @(posedge clk_sys_i);
      cell_low_i <= '0;
      $display("test open wire done");
   endtask : t_open_wire
   // main sequence
   initial begin
      {rstn_i, psel_i, penable_i, pwrite_i, stack_over_thr_i, pack_over_thr_i} = '0;
      {rst_cmd, cfo_cmd, dfo_cmd, prot_cmd, paddr_i, pwdata_i, cell_low_i, alarm_events_i} = '0;
      hard_reset();
      t_basic();
      t_fets();
      t_pins();
      t_alarm();
      t_fuse();
      t_rst_pin();
      t_open_wire();
      print_verdict();
   end
endmodule : test_pack_protect_pin_control
`default_nettype wire
